// ===== shared/spi_msg_defs.svh
// constants for the serial frame decoder: field positions, identifiers, timing, register map
`ifndef SPI_MSG_DEFS_SVH
`define SPI_MSG_DEFS_SVH

`define FRAME_W 16
`define PAR_BIT 15
`define FLAG_BIT 14
`define SEL_HI 14
`define SEL_LO 10
`define DATA_HI 9
`define FSEL_HI 5
`define FSEL_LO 3

`define SEL_GATE_SOURCE 5'h08
`define SEL_FREQ 5'h09
`define SEL_DRV1 5'h0A

`define SYS_CLK_HZ 20000000
`define FREQ0_HZ 3900
`define FREQ1_HZ 4500
`define FREQ2_HZ 5000
`define FREQ3_HZ 4200
`define FREQ4_HZ 3600
`define FREQ5_HZ 3400
`define FREQ6_HZ 3200
`define FREQ7_HZ 3000
`define PERIOD_W 13

`define DUTY_ZERO 8'h00
`define DUTY_MIN 8'h1A
`define DUTY_MAX 8'hE5
`define DUTY_FULL 8'hFF

`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_FREQ 8'h0C
`define REG_TARGET 8'h10
`define REG_DUTY 8'h14
`define REG_LAST_RX 8'h18

`define EV_W 5
`define EV_FRAME 0
`define EV_PARITY 1
`define EV_FREQ 2
`define EV_TARGET 3
`define EV_DUTY_REJ 4

`define CTRL_RESET 2'h0
`define FREQ_RESET 3'h0

`endif

// ===== shared/spi_msg_pkg.sv
// types shared by the frame shifter and the frame decoder
`include "spi_msg_defs.svh"
package spi_msg_pkg;
    typedef enum logic [1:0] {RESP_NONE, RESP_GATE, RESP_TEMP, RESP_DRV1} resp_kind_e;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic cs_n_s1;
        logic cs_n_s2;
        logic cs_n_d;
        logic mosi_s1;
        logic mosi_s2;
        logic [`FRAME_W-1:0] rx;
        logic [`FRAME_W-1:0] tx;
        logic [4:0] cnt;
        logic done;
        logic len_ok;
        logic [`FRAME_W-1:0] word;
    } shifter_s;

    typedef struct packed {
        resp_kind_e resp;
        logic perr;
        logic [2:0] freq_sel;
        logic [9:0] target;
        logic [7:0] duty;
        logic [1:0] ctrl;
        logic [`EV_W-1:0] status;
        logic [`EV_W-1:0] mask;
        logic [`FRAME_W-1:0] last_rx;
        logic [31:0] rdata;
        logic [`PERIOD_W-1:0] pwm_cnt;
        logic pwm_wrap;
    } decoder_s;
endpackage

// ===== shared/frame_if.sv
// interface carrying whole frames between the serial shifter and the decoder
`timescale 1ns/10ps
`include "spi_msg_defs.svh"
interface frame_if;
    logic rx_done;
    logic rx_len_ok;
    logic [`FRAME_W-1:0] rx_word;
    logic [`FRAME_W-1:0] tx_word;
    modport shifter (output rx_done, output rx_len_ok, output rx_word, input tx_word);
    modport decoder (input rx_done, input rx_len_ok, input rx_word, output tx_word);
endinterface

// ===== design/spi_frame_shifter.sv
// serial shifter: synchronises the link pins, collects frames and shifts out the answer
`timescale 1ns/10ps
`include "spi_msg_defs.svh"
module spi_frame_shifter
    import spi_msg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    frame_if.shifter fi
);
    shifter_s st_r;
    shifter_s st_nxt;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    // edges are taken from the second stage only
    assign cs_fall = st_r.cs_n_d & ~st_r.cs_n_s2;
    assign cs_rise = ~st_r.cs_n_d & st_r.cs_n_s2;
    assign sclk_rise = ~st_r.sclk_d & st_r.sclk_s2;
    assign sclk_fall = st_r.sclk_d & ~st_r.sclk_s2;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sclk_s1 = sclk_i;
        st_nxt.sclk_s2 = st_r.sclk_s1;
        st_nxt.sclk_d = st_r.sclk_s2;
        st_nxt.cs_n_s1 = cs_n_i;
        st_nxt.cs_n_s2 = st_r.cs_n_s1;
        st_nxt.cs_n_d = st_r.cs_n_s2;
        st_nxt.mosi_s1 = mosi_i;
        st_nxt.mosi_s2 = st_r.mosi_s1;
        st_nxt.done = 1'b0;
        if (cs_fall)
        begin
            st_nxt.tx = fi.tx_word;
            st_nxt.cnt = 5'h00;
        end
        else if (!st_r.cs_n_s2)
        begin
            if (sclk_rise)
            begin
                st_nxt.rx = {st_r.rx[`FRAME_W-2:0], st_r.mosi_s2};
                // saturate so an overlong frame never wraps back to a valid length
                if (st_r.cnt != 5'h1F)
                begin
                    st_nxt.cnt = st_r.cnt + 5'h01;
                end
            end
            if (sclk_fall)
            begin
                st_nxt.tx = {st_r.tx[`FRAME_W-2:0], 1'b0};
            end
        end
        if (cs_rise)
        begin
            st_nxt.done = 1'b1;
            st_nxt.word = st_r.rx;
            st_nxt.len_ok = (st_r.cnt == 5'h10);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
            st_r.sclk_s1 <= 1'b0;
            st_r.cs_n_s1 <= 1'b1;
            st_r.cs_n_s2 <= 1'b1;
            st_r.cs_n_d <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign miso_o = st_r.tx[`FRAME_W-1];
    assign miso_oe_o = ~st_r.cs_n_s2;
    assign fi.rx_done = st_r.done;
    assign fi.rx_len_ok = st_r.len_ok;
    assign fi.rx_word = st_r.word;

    chk_frame_length: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cs_rise && st_r.cnt != 5'h10 |=> fi.rx_done && !fi.rx_len_ok)
        else $error("short or long frame not marked bad");

    chk_answer_loaded: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cs_fall |=> st_r.tx == $past(fi.tx_word) && miso_oe_o)
        else $error("answer word not loaded at frame start");
endmodule // spi_frame_shifter

// ===== design/spi_msg_decoder.sv
// frame decoder for gate-source readout, valve frequency select and driver-one set point
// What this block does
// - selector 01000 in bits 14:10 requests the gate-source sample; payload zeros.
// - answer to that request carries the 10-bit gate-source sample in bits 9:0.
// - every answer has parity in bit 15 and previous frame's parity or length error in 14.
// - selector 01001 loads 3-bit frequency select from bits 5:3; 000..010 give 3.9/4.5/5.0 kHz.
// - frequency codes 011, 100, 101 give 4.2, 3.6 and 3.4 kHz.
// - frequency codes 110 and 111 give 3.2 and 3.0 kHz; other payload bits zero.
// - answer to the frequency frame carries averaged die temperature in bits 9:0.
// - regulation on: driver-one frame bits 9:0 set the 10-bit current target.
// - regulation off: bits 9:2 set duty; only 0, full and 10..90 percent allowed.
// - readback with regulation on: select 0 gives target, 1 gives applied duty.
`timescale 1ns/10ps
`include "spi_msg_defs.svh"
module spi_msg_decoder
    import spi_msg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic [9:0] predriver_gate_source_sample_i,
    input wire logic [9:0] die_temp_sample_i,
    input wire logic [7:0] applied_duty_i,
    input wire logic [9:0] driver_one_current_sample_i,
    output logic [2:0] valve_pwm_freq_select_o,
    output logic [`PERIOD_W-1:0] valve_pwm_period_o,
    output logic valve_pwm_wrap_o,
    output logic [9:0] driver_one_target_o,
    output logic [7:0] driver_one_duty_o,
    output logic regulation_off_pair_a_o,
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o
);
    frame_if fi();
    decoder_s st_r;
    decoder_s st_nxt;
    logic [`SEL_HI-`SEL_LO:0] rx_sel;
    logic frame_good;
    logic frame_bad;
    logic regulation_off_pair_a;
    logic readback_select;
    logic [9:0] resp_data;
    logic [`FRAME_W-2:0] resp_body;
    logic [`EV_W-1:0] events;
    logic [`EV_W-1:0] clr;
    logic [7:0] rx_duty;

    // frames use odd parity over all sixteen bits
    function automatic logic parity_ok(input logic [`FRAME_W-1:0] w);
        parity_ok = ^w;
    endfunction

    // period in system clocks, rounded down
    function automatic logic [`PERIOD_W-1:0] period_of(input logic [2:0] code);
        int hz;
        hz = `FREQ0_HZ;
        case (code)
            3'h0: hz = `FREQ0_HZ;
            3'h1: hz = `FREQ1_HZ;
            3'h2: hz = `FREQ2_HZ;
            3'h3: hz = `FREQ3_HZ;
            3'h4: hz = `FREQ4_HZ;
            3'h5: hz = `FREQ5_HZ;
            3'h6: hz = `FREQ6_HZ;
            default: hz = `FREQ7_HZ;
        endcase
        period_of = `PERIOD_W'(`SYS_CLK_HZ / hz);
    endfunction

    function automatic logic duty_allowed(input logic [7:0] d);
        duty_allowed = (d == `DUTY_ZERO) || (d == `DUTY_FULL) || (d >= `DUTY_MIN && d <= `DUTY_MAX);
    endfunction

    spi_frame_shifter u_shifter (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .mosi_i(mosi_i),
        .miso_o(miso_o),
        .miso_oe_o(miso_oe_o),
        .fi(fi.shifter)
    );

    assign rx_sel = fi.rx_word[`SEL_HI:`SEL_LO];
    assign frame_good = fi.rx_done & fi.rx_len_ok & parity_ok(fi.rx_word);
    assign frame_bad = fi.rx_done & ~frame_good;
    assign regulation_off_pair_a = st_r.ctrl[0];
    assign readback_select = st_r.ctrl[1];
    // low two payload bits carry nothing in duty mode
    assign rx_duty = fi.rx_word[`DATA_HI:2];

    // answer data follows the selector of the previous frame; zero after a bad frame
    always_comb
    begin
        resp_data = 10'h000;
        case (st_r.resp)
            RESP_GATE: resp_data = predriver_gate_source_sample_i;
            RESP_TEMP: resp_data = die_temp_sample_i;
            RESP_DRV1:
            begin
                if (!regulation_off_pair_a)
                begin
                    resp_data = readback_select ? {2'h0, applied_duty_i} : st_r.target;
                end
                else
                begin
                    resp_data = readback_select ? driver_one_current_sample_i : {st_r.duty, 2'h0};
                end
            end
            default: resp_data = 10'h000;
        endcase
    end

    // bits 13:10 are don't-care and read back as zero
    assign resp_body = {st_r.perr, 4'h0, resp_data};
    assign fi.tx_word = {~^resp_body, resp_body};

    always_comb
    begin
        events = '0;
        clr = '0;
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        if (fi.rx_done)
        begin
            events[`EV_FRAME] = 1'b1;
            st_nxt.perr = frame_bad;
            st_nxt.resp = RESP_NONE;
            st_nxt.last_rx = fi.rx_word;
        end
        if (frame_bad)
        begin
            events[`EV_PARITY] = 1'b1;
        end
        if (frame_good)
        begin
            if (rx_sel == `SEL_GATE_SOURCE)
            begin
                st_nxt.resp = RESP_GATE;
            end
            else if (rx_sel == `SEL_FREQ)
            begin
                st_nxt.resp = RESP_TEMP;
                st_nxt.freq_sel = fi.rx_word[`FSEL_HI:`FSEL_LO];
                events[`EV_FREQ] = 1'b1;
            end
            else if (rx_sel == `SEL_DRV1)
            begin
                st_nxt.resp = RESP_DRV1;
                if (!regulation_off_pair_a)
                begin
                    st_nxt.target = fi.rx_word[`DATA_HI:0];
                    events[`EV_TARGET] = 1'b1;
                end
                else if (duty_allowed(rx_duty))
                begin
                    st_nxt.duty = rx_duty;
                    events[`EV_TARGET] = 1'b1;
                end
                else
                begin
                    // a forbidden duty keeps the previous one rather than clamping
                    events[`EV_DUTY_REJ] = 1'b1;
                end
            end
        end

        if (reg_wr_i)
        begin
            if (reg_addr_i == `REG_CTRL)
            begin
                st_nxt.ctrl = reg_wdata_i[1:0];
            end
            else if (reg_addr_i == `REG_STATUS)
            begin
                clr = reg_wdata_i[`EV_W-1:0];
            end
            else if (reg_addr_i == `REG_MASK)
            begin
                st_nxt.mask = reg_wdata_i[`EV_W-1:0];
            end
        end
        // an event in the clearing cycle survives
        st_nxt.status = (st_r.status & ~clr) | events;

        if (reg_rd_i)
        begin
            if (reg_addr_i == `REG_CTRL)
            begin
                st_nxt.rdata = {30'h0, st_r.ctrl};
            end
            else if (reg_addr_i == `REG_STATUS)
            begin
                st_nxt.rdata = {27'h0, st_r.status};
            end
            else if (reg_addr_i == `REG_MASK)
            begin
                st_nxt.rdata = {27'h0, st_r.mask};
            end
            else if (reg_addr_i == `REG_FREQ)
            begin
                st_nxt.rdata = {29'h0, st_r.freq_sel};
            end
            else if (reg_addr_i == `REG_TARGET)
            begin
                st_nxt.rdata = {22'h0, st_r.target};
            end
            else if (reg_addr_i == `REG_DUTY)
            begin
                st_nxt.rdata = {24'h0, st_r.duty};
            end
            else if (reg_addr_i == `REG_LAST_RX)
            begin
                st_nxt.rdata = {16'h0, st_r.last_rx};
            end
        end

        // shared carrier for all four valve outputs
        st_nxt.pwm_wrap = 1'b0;
        if (st_r.pwm_cnt >= period_of(st_r.freq_sel) - `PERIOD_W'(1))
        begin
            st_nxt.pwm_cnt = '0;
            st_nxt.pwm_wrap = 1'b1;
        end
        else
        begin
            st_nxt.pwm_cnt = st_r.pwm_cnt + `PERIOD_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign valve_pwm_freq_select_o = st_r.freq_sel;
    assign valve_pwm_period_o = period_of(st_r.freq_sel);
    assign valve_pwm_wrap_o = st_r.pwm_wrap;
    assign driver_one_target_o = st_r.target;
    assign driver_one_duty_o = st_r.duty;
    assign regulation_off_pair_a_o = regulation_off_pair_a;
    assign reg_rdata_o = st_r.rdata;
    assign irq_o = |(st_r.status & st_r.mask);

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    chk_gate_answer: assert property (fi.rx_done && frame_good && rx_sel == 5'h08
        |=> st_r.resp == RESP_GATE)
        else $error("gate-source request not recorded");

    chk_gate_data: assert property (st_r.resp == RESP_GATE
        |-> fi.tx_word[9:0] == predriver_gate_source_sample_i && fi.tx_word[13:10] == 4'h0)
        else $error("gate-source answer data wrong");

    chk_flag_parity: assert property (fi.rx_done
        |=> fi.tx_word[14] == $past(frame_bad) && ^fi.tx_word == 1'b1)
        else $error("answer flag or parity wrong");

    chk_freq_load: assert property (frame_good && rx_sel == 5'h09
        |=> valve_pwm_freq_select_o == $past(fi.rx_word[5:3]))
        else $error("frequency select not loaded");

    chk_freq_fast: assert property (valve_pwm_freq_select_o == 3'h2 |-> valve_pwm_period_o == 13'd4000)
        else $error("5.0 kHz period wrong");

    chk_freq_mid: assert property (valve_pwm_freq_select_o == 3'h5 |-> valve_pwm_period_o == 13'd5882)
        else $error("3.4 kHz period wrong");

    chk_freq_slow: assert property (valve_pwm_freq_select_o == 3'h7 |-> valve_pwm_period_o == 13'd6666)
        else $error("3.0 kHz period wrong");

    chk_temp_data: assert property (st_r.resp == RESP_TEMP |-> fi.tx_word[9:0] == die_temp_sample_i)
        else $error("temperature answer wrong");

    chk_target_load: assert property (frame_good && rx_sel == 5'h0A && !regulation_off_pair_a
        |=> driver_one_target_o == $past(fi.rx_word[9:0]))
        else $error("current target not loaded");

    chk_duty_load: assert property (frame_good && rx_sel == 5'h0A && regulation_off_pair_a
        && !duty_allowed(rx_duty) |=> $stable(driver_one_duty_o) && st_r.status[4])
        else $error("forbidden duty accepted");

    chk_readback: assert property (st_r.resp == RESP_DRV1 && !regulation_off_pair_a && readback_select
        |-> fi.tx_word[9:0] == {2'h0, applied_duty_i})
        else $error("applied duty readback wrong");

    chk_bad_discard: assert property (frame_bad
        |=> $stable(driver_one_target_o) && $stable(valve_pwm_freq_select_o) && st_r.resp == RESP_NONE)
        else $error("bad frame payload used");
endmodule // spi_msg_decoder

// ===== verif/spi_host_model.sv
// host-side serial master model: sends one frame and captures the answer
`timescale 1ns/10ps
module spi_host_model
(
    input wire logic clk_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_i
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // 400 ns link period is eight system clocks; the link clock stands low between frames
    // n below 16 sends a cut frame made of the top n bits of w
    task automatic xfer_len(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            mosi_o <= w[15 - i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            // an undriven answer line reads inverted, so a missing enable shows up
            r[15 - i] = miso_oe_i ? miso_i : ~miso_i;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        // a released data line must not keep showing the last bit
        mosi_o <= ~mosi_o;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        xfer_len(w, 16, r);
    endtask
endmodule // spi_host_model

// ===== verif/spi_msg_decoder_ids_8_to_10_bench.sv
// self-checking bench for the frame decoder, driven through the host master model
`timescale 1ns/10ps
`include "spi_msg_defs.svh"
module spi_msg_decoder_ids_8_to_10_bench;
    typedef struct packed {
        logic [1:0] ctrl;
        logic [4:0] sel;
        logic [9:0] pl;
        logic [2:0] fq;
        logic [9:0] tg;
        logic [7:0] dt;
        logic [9:0] ans;
    } row_s;

    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    wire sclk, cs_n, mosi;
    logic miso, miso_oe, wrap, roff, irq, wr, rd;
    logic [9:0] gs, temp, cur, target;
    logic [7:0] ad, duty;
    logic [2:0] freq;
    logic [`PERIOD_W-1:0] period;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [15:0] ans;
    row_s rows [18];
    int hz [8] = '{3900, 4500, 5000, 4200, 3600, 3400, 3200, 3000};
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int gap = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    spi_host_model host (.clk_i(clk_sys_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
        .miso_oe_i(miso_oe));

    spi_msg_decoder dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_o(miso_oe), .predriver_gate_source_sample_i(gs),
        .die_temp_sample_i(temp), .applied_duty_i(ad), .driver_one_current_sample_i(cur),
        .valve_pwm_freq_select_o(freq), .valve_pwm_period_o(period), .valve_pwm_wrap_o(wrap),
        .driver_one_target_o(target), .driver_one_duty_o(duty), .regulation_off_pair_a_o(roff),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .irq_o(irq));

    // odd parity over the whole frame
    function automatic logic [15:0] mk(input logic [4:0] s, input logic [9:0] p);
        mk = {~^{s, p}, s, p};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // about 17000 cycles expected, most of them in the carrier period measurement
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            results();
        end
    end

    initial
    begin
        gs = 10'h2A5;
        temp = 10'h1C3;
        cur = 10'h2E7;
        ad = 8'h5C;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        rows[0] = '{2'h0, `SEL_GATE_SOURCE, 10'h000, 3'h0, 10'h000, 8'h00, 10'h2A5};
        for (int k = 0; k < 8; k++)
            rows[k + 1] = '{2'h0, `SEL_FREQ, {4'h0, 3'(k), 3'h0}, 3'(k), 10'h000, 8'h00, 10'h1C3};
        rows[9] = '{2'h0, `SEL_DRV1, 10'h3FF, 3'h7, 10'h3FF, 8'h00, 10'h3FF};
        rows[10] = '{2'h2, `SEL_DRV1, 10'h155, 3'h7, 10'h155, 8'h00, {2'h0, 8'h5C}};
        rows[11] = '{2'h1, `SEL_DRV1, {8'h1A, 2'h3}, 3'h7, 10'h155, 8'h1A, {8'h1A, 2'h0}};
        rows[12] = '{2'h1, `SEL_DRV1, {8'h19, 2'h0}, 3'h7, 10'h155, 8'h1A, {8'h1A, 2'h0}};
        rows[13] = '{2'h1, `SEL_DRV1, {8'hFF, 2'h1}, 3'h7, 10'h155, 8'hFF, {8'hFF, 2'h0}};
        rows[14] = '{2'h1, `SEL_DRV1, {8'hE6, 2'h2}, 3'h7, 10'h155, 8'hFF, {8'hFF, 2'h0}};
        rows[15] = '{2'h1, `SEL_DRV1, {8'hE5, 2'h0}, 3'h7, 10'h155, 8'hE5, {8'hE5, 2'h0}};
        rows[16] = '{2'h1, `SEL_DRV1, {8'h00, 2'h0}, 3'h7, 10'h155, 8'h00, {8'h00, 2'h0}};
        rows[17] = '{2'h3, `SEL_DRV1, {8'h80, 2'h0}, 3'h7, 10'h155, 8'h80, 10'h2E7};
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk("period after reset", 20000000 / hz[0], period);
        for (int k = 0; k < 18; k++)
        begin
            wr_reg(`REG_CTRL, {30'h0, rows[k].ctrl});
            host.xfer(mk(rows[k].sel, rows[k].pl), ans);
            // the answer to a frame shifts out during the following one
            host.xfer(mk(5'h00, 10'h000), ans);
            chk("answer data", rows[k].ans, ans[9:0]);
            chk("answer flag", 1'b0, ans[14]);
            chk("answer parity", 1'b1, ^ans);
            chk("freq select", rows[k].fq, freq);
            chk("period", 20000000 / hz[rows[k].fq], period);
            chk("target", rows[k].tg, target);
            chk("duty", rows[k].dt, duty);
            chk("regulation off", rows[k].ctrl[0], roff);
            $display("row %0d done", k);
        end

        wr_reg(`REG_MASK, 32'h2);
        wr_reg(`REG_STATUS, 32'h1F);
        host.xfer(mk(`SEL_FREQ, 10'h028) ^ 16'h8000, ans);
        chk("freq kept", 3'h7, freq);
        chk("irq raised", 1'b1, irq);
        host.xfer(mk(5'h00, 10'h000), ans);
        chk("error flag", 1'b1, ans[14]);
        chk("error data", 10'h000, ans[9:0]);
        rd_reg(`REG_STATUS, v);
        chk("status error", 1'b1, v[1]);
        wr_reg(`REG_STATUS, 32'h2);
        @(posedge clk_sys_i);
        chk("irq cleared", 1'b0, irq);
        wr_reg(`REG_MASK, 32'h0);
        host.xfer(mk(`SEL_FREQ, 10'h028) ^ 16'h8000, ans);
        chk("irq masked", 1'b0, irq);
        host.xfer_len(mk(`SEL_FREQ, 10'h028), 15, ans);
        chk("masked error flag", 1'b1, ans[14]);
        chk("short frame freq kept", 3'h7, freq);
        host.xfer(mk(5'h00, 10'h000), ans);
        chk("short frame flag", 1'b1, ans[14]);
        chk("short frame data", 10'h000, ans[9:0]);
        $display("parity error test done");

        rd_reg(`REG_FREQ, v);
        chk("freq reg", 32'h7, v);
        wr_reg(`REG_FREQ, 32'h0);
        rd_reg(`REG_FREQ, v);
        chk("freq read only", 32'h7, v);
        rd_reg(8'h40, v);
        chk("unmapped read", 32'h0, v);
        rd_reg(`REG_TARGET, v);
        chk("target reg", 32'h155, v);
        rd_reg(`REG_DUTY, v);
        chk("duty reg", 32'h80, v);
        $display("register test done");

        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk("reset freq", 3'h0, freq);
        chk("reset period", 20000000 / hz[0], period);
        chk("reset target", 10'h000, target);
        chk("reset duty", 8'h00, duty);
        chk("reset irq", 1'b0, irq);
        chk("reset miso enable", 1'b0, miso_oe);
        $display("reset test done");
        @(posedge clk_sys_i);
        while (wrap !== 1'b1)
            @(posedge clk_sys_i);
        gap = 0;
        do
        begin
            @(posedge clk_sys_i);
            gap++;
        end
        while (wrap !== 1'b1);
        chk("carrier period", 20000000 / hz[0], gap);
        $display("carrier test done");
        results();
    end
endmodule // spi_msg_decoder_ids_8_to_10_bench
